// ---- spr_map.svh ----
// Register offsets, fields, characters and timing for the serial port
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH
`define SPR_TXD_OFS 4'h0
`define SPR_RXD_OFS 4'h4
`define SPR_STAT_OFS 4'h8
`define SPR_CTRL_OFS 4'hc
`define SPR_STAT_OVR 3
`define SPR_STAT_FRM 4
`define SPR_CTRL_HOLD 0
`define SPR_XOFF 8'h13
`define SPR_XON 8'h11
`define SPR_RESP_OKAY 2'h0
`define SPR_RESP_SLVERR 2'h2
`define SPR_CLK_HZ 50000000
`define SPR_BASE_BAUD 9600
`define SPR_BASE_DIV (`SPR_CLK_HZ / `SPR_BASE_BAUD)
`define SPR_CNT_W 20
`endif

// ---- spr_pkg.sv ----
// State types of the serial port
package spr_pkg;
	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_START = 4'h2,
		TX_DATA = 4'h4,
		TX_STOP = 4'h8
	} spr_tx_e;
	typedef enum logic [3:0] {
		RX_IDLE = 4'h1,
		RX_START = 4'h2,
		RX_DATA = 4'h4,
		RX_STOP = 4'h8
	} spr_rx_e;
endpackage : spr_pkg

// ---- spr_bit_timer.sv ----
// Bit period timer, optional half period before the first tick
`timescale 1ns/1ps
module spr_bit_timer #(
	parameter int CW = 20
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	input wire logic run,
	input wire logic half_first,
	input wire logic [CW-1:0] period,
	// Result
	output logic tick
);
	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	assign tick = run & (cnt == CW'(1));
	assign next_cnt = !run ? (half_first ? (period >> 1) : period) :
		tick ? period : cnt - CW'(1);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt <= '0;
		else
			cnt <= next_cnt;
	end
endmodule : spr_bit_timer

// ---- spr_serial_port.sv ----
// Serial port with switch-set rate and flow control, AXI4-Lite slave
`timescale 1ns/1ps
`include "spr_map.svh"
// Overview of operation
// - The bit rate is 9600 for switch code 000, halving per step to 75.
// - The rate code is caught once after power-up and then held.
// - Flow enable switch 0 turns every kind of flow control off.
// - With flow on, kind switch 0 picks line handshake, 1 picks characters.
// - In character mode the port sends 0x13 when it cannot take more data.
// - In character mode the port sends 0x11 when it can take data again.
// - In line mode a dedicated output line tells the host we can receive.
// - Default line variant: host drives RTS in, the port drives CTS out.
// - Straps pick the line variant; the output strap also picks which line is held high outside line mode.
// - Flow enable and kind switches are caught once after power-up.
// - Other line variant: host drives DTR in, the port drives DSR out.
module spr_serial_port #(
	parameter int BASE_DIV = `SPR_BASE_DIV,
	parameter int CW = `SPR_CNT_W
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Rear switches and board straps
	input wire logic rate_code_msb,
	input wire logic rate_code_mid,
	input wire logic rate_code_lsb,
	input wire logic flow_enable_switch,
	input wire logic handshake_kind_switch,
	input wire logic handshake_input_strap,
	input wire logic handshake_output_strap,
	// Serial link
	input wire logic rxd,
	input wire logic rts_in,
	input wire logic dtr_in,
	output logic txd,
	output logic cts_out,
	output logic dsr_out,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import spr_pkg::*;

	logic cfg_done, flow_en_q, kind_q, in_strap_q, out_strap_q;
	logic [2:0] rate_q;
	logic aw_got, w_got, ctrl_hold;
	logic [3:0] aw_addr, w_strb;
	logic [31:0] w_data;
	logic tx_pend, adv_ready, rx_full, overrun, frame_err;
	logic [7:0] tx_buf, tx_sh, rx_buf, rx_sh;
	logic [2:0] tx_cnt, rx_cnt;
	logic [CW-1:0] tx_gap;
	spr_tx_e tx_state;
	spr_rx_e rx_state;
	wire tx_tick;
	wire rx_tick;

	// Mode and readiness
	wire sw_mode = flow_en_q & kind_q;
	wire hw_mode = flow_en_q & ~kind_q;
	wire host_line = in_strap_q ? dtr_in : rts_in;
	wire host_ok = ~hw_mode | host_line;
	wire dev_ready = ~rx_full & ~ctrl_hold;
	wire rdy_level = ~hw_mode | dev_ready;
	wire [CW-1:0] period = CW'(BASE_DIV) << rate_q;
	wire tx_idle = tx_state == TX_IDLE;
	wire tx_run = ~tx_idle;
	wire rx_run = rx_state != RX_IDLE;
	wire need_off = sw_mode & adv_ready & ~dev_ready;
	wire need_on = sw_mode & ~adv_ready & dev_ready;
	wire load_flow = cfg_done & tx_idle & (need_off | need_on);
	wire load_data = cfg_done & tx_idle & ~need_off & ~need_on &
		tx_pend & host_ok;
	wire [7:0] flow_char = need_off ? `SPR_XOFF : `SPR_XON;
	wire stop_ok = rx_state == RX_STOP & rx_tick & rxd;
	wire stop_bad = rx_state == RX_STOP & rx_tick & ~rxd;

	// Bus decode
	wire wr_go = aw_got & w_got & ~s_axi_bvalid;
	wire wr_map = aw_addr == `SPR_TXD_OFS | aw_addr == `SPR_RXD_OFS |
		aw_addr == `SPR_STAT_OFS | aw_addr == `SPR_CTRL_OFS;
	wire wr_txd = wr_go & aw_addr == `SPR_TXD_OFS & w_strb[0];
	wire wr_stat = wr_go & aw_addr == `SPR_STAT_OFS & w_strb[0];
	wire wr_ctrl = wr_go & aw_addr == `SPR_CTRL_OFS & w_strb[0];
	wire take_txd = wr_txd & ~tx_pend;
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire rd_map = s_axi_araddr == `SPR_TXD_OFS |
		s_axi_araddr == `SPR_RXD_OFS | s_axi_araddr == `SPR_STAT_OFS |
		s_axi_araddr == `SPR_CTRL_OFS;
	wire rd_rxd = ar_hs & s_axi_araddr == `SPR_RXD_OFS;
	wire [31:0] stat_word = {18'h0, adv_ready, out_strap_q, in_strap_q,
		kind_q, flow_en_q, rate_q, host_line, frame_err, overrun, tx_run,
		tx_pend, rx_full};
	wire [31:0] rd_word = s_axi_araddr == `SPR_RXD_OFS ? {24'h0, rx_buf} :
		s_axi_araddr == `SPR_STAT_OFS ? stat_word :
		s_axi_araddr == `SPR_CTRL_OFS ? {31'h0, ctrl_hold} : 32'h0;

	spr_bit_timer #(.CW(CW)) u_tx_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(tx_run),
		.half_first(1'b0),
		.period(period),
		.tick(tx_tick)
	);
	// Receiver samples mid-bit
	spr_bit_timer #(.CW(CW)) u_rx_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(rx_run),
		.half_first(1'b1),
		.period(period),
		.tick(rx_tick)
	);

	// Switches and straps caught once after reset release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_done <= 1'b0;
			rate_q <= 3'h0;
			flow_en_q <= 1'b0;
			kind_q <= 1'b0;
			in_strap_q <= 1'b0;
			out_strap_q <= 1'b0;
		end else if (!cfg_done) begin
			cfg_done <= 1'b1;
			rate_q <= {rate_code_msb, rate_code_mid, rate_code_lsb};
			flow_en_q <= flow_enable_switch;
			kind_q <= handshake_kind_switch;
			in_strap_q <= handshake_input_strap;
			out_strap_q <= handshake_output_strap;
		end
	end

	// AXI4-Lite write channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPR_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~aw_got &
				~s_axi_bvalid;
			s_axi_wready <= s_axi_wvalid & ~s_axi_wready & ~w_got &
				~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go)
				aw_got <= 1'b0;
			if (s_axi_wvalid & s_axi_wready) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go)
				w_got <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `SPR_RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_map ? `SPR_RESP_OKAY : `SPR_RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Buffers, flags and handshake lines
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_hold <= 1'b0;
			tx_buf <= 8'h0;
			tx_pend <= 1'b0;
			rx_buf <= 8'h0;
			rx_full <= 1'b0;
			overrun <= 1'b0;
			frame_err <= 1'b0;
			adv_ready <= 1'b1;
			cts_out <= 1'b0;
			dsr_out <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_hold <= w_data[`SPR_CTRL_HOLD];
			if (take_txd)
				tx_buf <= w_data[7:0];
			tx_pend <= take_txd | (tx_pend & ~load_data);
			if (stop_ok & ~rx_full)
				rx_buf <= rx_sh;
			rx_full <= stop_ok | (rx_full & ~rd_rxd);
			overrun <= (stop_ok & rx_full) |
				(overrun & ~(wr_stat & w_data[`SPR_STAT_OVR]));
			frame_err <= stop_bad |
				(frame_err & ~(wr_stat & w_data[`SPR_STAT_FRM]));
			if (load_flow)
				adv_ready <= ~need_off;
			cts_out <= ~out_strap_q & rdy_level;
			dsr_out <= out_strap_q & rdy_level;
		end
	end

	// Transmitter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state <= TX_IDLE;
			tx_sh <= 8'h0;
			tx_cnt <= 3'h0;
			txd <= 1'b1;
		end else begin
			case (tx_state)
			TX_IDLE: if (load_flow | load_data) begin
				tx_state <= TX_START;
				tx_sh <= load_flow ? flow_char : tx_buf;
				txd <= 1'b0;
			end
			TX_START: if (tx_tick) begin
				tx_state <= TX_DATA;
				txd <= tx_sh[0];
				tx_sh <= {1'b0, tx_sh[7:1]};
				tx_cnt <= 3'h0;
			end
			TX_DATA: if (tx_tick) begin
				if (tx_cnt == 3'h7) begin
					tx_state <= TX_STOP;
					txd <= 1'b1;
				end else begin
					txd <= tx_sh[0];
					tx_sh <= {1'b0, tx_sh[7:1]};
					tx_cnt <= tx_cnt + 3'h1;
				end
			end
			TX_STOP: if (tx_tick) begin
				tx_state <= TX_IDLE;
			end
			default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Receiver
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state <= RX_IDLE;
			rx_sh <= 8'h0;
			rx_cnt <= 3'h0;
		end else begin
			case (rx_state)
			RX_IDLE: if (!rxd) begin
				rx_state <= RX_START;
			end
			RX_START: if (rx_tick) begin
				rx_state <= rxd ? RX_IDLE : RX_DATA;
				rx_cnt <= 3'h0;
			end
			RX_DATA: if (rx_tick) begin
				rx_sh <= {rxd, rx_sh[7:1]};
				rx_cnt <= rx_cnt + 3'h1;
				if (rx_cnt == 3'h7)
					rx_state <= RX_STOP;
			end
			RX_STOP: if (rx_tick) begin
				rx_state <= RX_IDLE;
			end
			default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_gap <= CW'(1);
		else if (!tx_run | tx_tick)
			tx_gap <= CW'(1);
		else
			tx_gap <= tx_gap + CW'(1);
	end

	sequence s_need_off;
		cfg_done && tx_idle && need_off;
	endsequence
	sequence s_need_on;
		cfg_done && tx_idle && need_on;
	endsequence
	sequence s_char_out(logic [7:0] c);
		tx_state == TX_START && tx_sh == c && !txd;
	endsequence
	sequence s_stop_bit;
		tx_state == TX_STOP && txd ##1 txd;
	endsequence

	property p_bit_time;
		tx_tick |-> tx_gap == (CW'(BASE_DIV) << rate_q);
	endproperty
	a_bit_time: assert property (p_bit_time)
		else $error("bit period does not match rate code");
	property p_rate_latch;
		cfg_done |=> $stable(rate_q);
	endproperty
	a_rate_latch: assert property (p_rate_latch)
		else $error("rate code changed after power-up");
	property p_flow_latch;
		cfg_done |=> $stable({flow_en_q, kind_q, in_strap_q, out_strap_q});
	endproperty
	a_flow_latch: assert property (p_flow_latch)
		else $error("flow settings changed after power-up");
	property p_no_flow_char;
		cfg_done && !flow_en_q && tx_idle && !tx_pend |=> tx_idle;
	endproperty
	a_no_flow_char: assert property (p_no_flow_char)
		else $error("transmit started with flow off and nothing queued");
	property p_no_flow_line;
		cfg_done && !flow_en_q |=> (out_strap_q ? dsr_out : cts_out);
	endproperty
	a_no_flow_line: assert property (p_no_flow_line)
		else $error("ready line dropped with flow control off");
	property p_sw_line;
		cfg_done && sw_mode |=> (cts_out || dsr_out);
	endproperty
	a_sw_line: assert property (p_sw_line)
		else $error("ready line dropped in character mode");
	property p_xoff;
		s_need_off |=> s_char_out(`SPR_XOFF) ##1 !txd;
	endproperty
	a_xoff: assert property (p_xoff)
		else $error("stop character not sent");
	property p_xon;
		s_need_on |=> s_char_out(`SPR_XON) ##1 !txd;
	endproperty
	a_xon: assert property (p_xon)
		else $error("resume character not sent");
	property p_hw_busy;
		hw_mode && !dev_ready |=> !cts_out && !dsr_out;
	endproperty
	a_hw_busy: assert property (p_hw_busy)
		else $error("ready line high while unable to receive");
	property p_cts;
		hw_mode && !out_strap_q |=> cts_out == $past(dev_ready) && !dsr_out;
	endproperty
	a_cts: assert property (p_cts)
		else $error("clear-to-send does not follow readiness");
	property p_dsr;
		hw_mode && out_strap_q |=> dsr_out == $past(dev_ready) && !cts_out;
	endproperty
	a_dsr: assert property (p_dsr)
		else $error("data-set-ready does not follow readiness");
	property p_host_hold;
		hw_mode && tx_idle && !host_line |=> tx_idle;
	endproperty
	a_host_hold: assert property (p_host_hold)
		else $error("transmit started while host line low");
	property p_frame;
		tx_state == TX_DATA && tx_tick && tx_cnt == 3'h7 |=> s_stop_bit;
	endproperty
	a_frame: assert property (p_frame)
		else $error("stop bit missing after eighth data bit");
endmodule : spr_serial_port

// ---- spr_host_model.sv ----
// Host serial port model: sends frames and decodes frames
`timescale 1ns/1ps
module spr_host_model (
	// Clock and bit period
	input wire logic aclk,
	input wire logic [15:0] period,
	// Serial lines
	input wire logic txd,
	output logic rxd
);
	logic [8:0] got[$];
	logic [7:0] b;
	initial rxd = 1'b1;
	task automatic send(input logic [7:0] d);
		rxd <= 1'b0;
		repeat (period) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rxd <= d[i];
			repeat (period) @(posedge aclk);
		end
		rxd <= 1'b1;
		repeat (period) @(posedge aclk);
	endtask : send
	// Bit 8 flags a missing stop bit
	always begin
		@(negedge txd);
		repeat (period / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (period) @(posedge aclk);
			b[i] = txd;
		end
		repeat (period) @(posedge aclk);
		got.push_back({~txd, b});
	end
endmodule : spr_host_model

// ---- tb_top.sv ----
// Self-checking bench for the switch-set serial port
`timescale 1ns/1ps
`include "spr_map.svh"
module tb_top;
	localparam int BDIV = 4;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [2:0] code = 3'h0;
	logic fe = 1'b0, kind = 1'b0, istr = 1'b0, ostr = 1'b0;
	logic rxd, txd, cts_out, dsr_out, rts_in = 1'b1, dtr_in = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0] bresp, rresp, resp;
	logic [15:0] period = 16'h4;
	logic [7:0] byt;
	int err_count = 0, n_checks = 0, seed = 33841;
	always #10 aclk = ~aclk;
	spr_host_model i_host (.aclk(aclk), .period(period), .txd(txd),
		.rxd(rxd));
	spr_serial_port #(.BASE_DIV(BDIV), .CW(20)) i_dut (.aclk(aclk),
		.aresetn(aresetn), .rate_code_msb(code[2]), .rate_code_mid(code[1]),
		.rate_code_lsb(code[0]), .flow_enable_switch(fe),
		.handshake_kind_switch(kind), .handshake_input_strap(istr),
		.handshake_output_strap(ostr), .rxd(rxd), .rts_in(rts_in),
		.dtr_in(dtr_in), .txd(txd), .cts_out(cts_out), .dsr_out(dsr_out),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	function automatic logic [8:0] exp_frame(logic [7:0] d);
		return {1'b0, d};
	endfunction : exp_frame
	// Expected {dsr_out, cts_out} for output strap and readiness
	function automatic logic [1:0] exp_lines(logic o, logic r);
		return o ? {r, 1'b0} : {1'b0, r};
	endfunction : exp_lines
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic setup(input logic [2:0] c, input logic f, k, i, o);
		aresetn <= 1'b0;
		code <= c;
		fe <= f;
		kind <= k;
		istr <= i;
		ostr <= o;
		period <= 16'(BDIV << c);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask : setup
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awready && !aw_done) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w_done) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd
	task automatic wait_rx();
		while (i_host.got.size() == 0) @(posedge aclk);
	endtask : wait_rx
	task automatic tx_byte();
		byt = 8'($random(seed));
		axi_wr(`SPR_TXD_OFS, {24'h0, byt});
	endtask : tx_byte
	initial begin
		// Every rate code; switches moved after power-up have no effect
		for (int c = 0; c < 8; c++) begin
			setup(3'(c), c[0], c[1], 1'b0, 1'b0);
			code <= ~code;
			fe <= ~fe;
			kind <= ~kind;
			tx_byte();
			wait_rx();
			chk(32'(i_host.got.pop_front()), 32'(exp_frame(byt)));
			axi_rd(`SPR_STAT_OFS);
			chk(32'(rd[10:6]), 32'({c[1], c[0], c[2:0]}));
		end
		// Character flow: stop code on full, resume code after read
		setup(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
		byt = 8'($random(seed));
		i_host.send(byt);
		wait_rx();
		chk(32'(i_host.got.pop_front()), 32'h13);
		chk(32'({dsr_out, cts_out}), 32'h1);
		axi_rd(`SPR_RXD_OFS);
		chk(rd, 32'(byt));
		wait_rx();
		chk(32'(i_host.got.pop_front()), 32'h11);
		// Line handshake under each strap pair
		for (int s = 0; s < 4; s++) begin
			setup(3'h0, 1'b1, 1'b0, s[0], s[1]);
			rts_in <= s[0];
			dtr_in <= !s[0];
			tx_byte();
			repeat (60) @(posedge aclk);
			chk(32'(i_host.got.size()), 32'h0);
			rts_in <= 1'b1;
			dtr_in <= 1'b1;
			wait_rx();
			chk(32'(i_host.got.pop_front()), 32'(exp_frame(byt)));
			i_host.send(8'($random(seed)));
			repeat (4) @(posedge aclk);
			chk(32'({dsr_out, cts_out}), 32'(exp_lines(s[1], 1'b0)));
			axi_rd(`SPR_RXD_OFS);
			repeat (3) @(posedge aclk);
			chk(32'({dsr_out, cts_out}), 32'(exp_lines(s[1], 1'b1)));
		end
		// Software hold drops the ready line in line mode
		axi_wr(`SPR_CTRL_OFS, 32'h1);
		repeat (3) @(posedge aclk);
		chk(32'({dsr_out, cts_out}), 32'(exp_lines(1'b1, 1'b0)));
		axi_rd(`SPR_CTRL_OFS);
		chk(rd, 32'h1);
		// Flow off: host lines ignored, no flow characters
		setup(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
		rts_in <= 1'b0;
		dtr_in <= 1'b0;
		i_host.send(8'h5a);
		repeat (60) @(posedge aclk);
		chk(32'(i_host.got.size()), 32'h0);
		chk(32'({dsr_out, cts_out}), 32'h1);
		axi_rd(`SPR_RXD_OFS);
		chk(rd, 32'h5a);
		tx_byte();
		wait_rx();
		chk(32'(i_host.got.pop_front()), 32'(exp_frame(byt)));
		// Unaligned offsets are refused
		axi_wr(4'h2, 32'h0);
		chk(32'(resp), 32'(`SPR_RESP_SLVERR));
		axi_rd(4'h6);
		chk(32'(resp), 32'(`SPR_RESP_SLVERR));
		chk(rd, 32'h0);
		finish_test();
	end
	initial begin
		repeat (30000) @(posedge aclk);
		err_count++;
		finish_test();
	end
endmodule : tb_top
